// File: logic/rxfc_top.sv
// receive fifo, hardware and software flow control of one uart channel
`timescale 1ns/100ps
`default_nettype none
module rxfc_top import rxfc_pkg::*; (
   input  wire logic       CLK_SYS,
   input  wire logic       RST,
   input  wire logic [2:0] ADDR,
   input  wire logic       WR_STB,
   input  wire logic       RD_STB,
   input  wire logic [7:0] WDATA,
   output logic      [7:0] RDATA,
   input  wire rxfc_char_t RX_CHAR,
   input  wire logic       RX_VALID,
   output logic            RX_READY,
   input  wire logic       CHAR_TICK,
   input  wire logic       CTS_N,
   output logic            TX_HOLD,
   output logic            SEND_VALID,
   output logic      [7:0] SEND_DATA,
   input  wire logic       SEND_READY,
   output logic            RTS_N,
   output logic            INT
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic       [7:0] ier_q;
   logic       [7:0] lcr_q;
   logic       [7:0] mcr_q;
   logic       [7:0] efr_q;
   logic       [7:0] xon1_q;
   logic       [7:0] xon2_q;
   logic       [7:0] xoff1_q;
   logic       [7:0] special_char_q;
   logic             fifo_en_q;
   logic       [1:0] trig_sel_q;
   logic             flag4_q;
   logic             flag5_q;
   logic             paused_q;
   logic             cts_q;
   logic             rts_n_q;
   logic             hold_q;
   logic             int_q;
   logic       [7:0] rdata_q;
   rxfc_char_t       mem_q [FIFO_DEPTH];
   logic       [4:0] wp_q;
   logic       [4:0] rp_q;
   logic       [5:0] cnt_q;
   rxfc_char_t       held_q;
   logic             held_v_q;
   logic             held_on_q;
   rxfc_fc_t         fc_q;
   rxfc_fc_t         fc_d;
   logic       [1:0] ticks_q;
   logic       [7:0] send_q;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire       enh    = lcr_q == LCR_ENH_KEY;
   wire       norm   = ~lcr_q[7];
   wire       wr_ier = WR_STB & norm & (ADDR == OFS_IER);
   wire       wr_fcr = WR_STB & norm & (ADDR == OFS_ISR);
   wire       wr_lcr = WR_STB & (ADDR == OFS_LCR);
   wire       wr_mcr = WR_STB & ~enh & (ADDR == OFS_MCR);
   wire       wr_efr = WR_STB & enh & (ADDR == OFS_EFR);
   wire       wr_x1n = WR_STB & enh & (ADDR == OFS_XON1);
   wire       wr_x2n = WR_STB & enh & (ADDR == OFS_XON2);
   wire       wr_x1f = WR_STB & enh & (ADDR == OFS_XOFF1);
   wire       wr_x2f = WR_STB & enh & (ADDR == OFS_SPECIAL_CHAR);
   wire       rd_isr = RD_STB & norm & (ADDR == OFS_ISR);
   wire       rhr_rd = RD_STB & norm & (ADDR == OFS_RHR) & (cnt_q != 6'h00);
   wire       efr4   = efr_q[4];
   // enhanced bits keep their value unless efr bit 4 unlocks them
   wire [7:0] ier_d = efr4 ? WDATA : {ier_q[7:4], WDATA[3:0]}; // RULE23
   wire [7:0] mcr_d = efr4 ? WDATA : {mcr_q[7:5], WDATA[4:0]}; // RULE23
   // fcr bit 1 or a change of bit 0 flushes the receive fifo
   wire       fifo_clr = wr_fcr & (WDATA[1] | (WDATA[0] != fifo_en_q));

   // ----------------------------------------------------------------
   // fill thresholds
   // ----------------------------------------------------------------
   wire [5:0] trig = TRIG_LVL[trig_sel_q];
   wire [5:0] hi   = HI_LVL[trig_sel_q];
   wire [5:0] lo   = LO_LVL[trig_sel_q];
   // without the fifo the path holds only the holding register
   wire [5:0] cap  = fifo_en_q ? FIFO_FULL : 6'h01;
   wire       full = cnt_q >= cap;

   // ----------------------------------------------------------------
   // incoming characters and flow character matching
   // ----------------------------------------------------------------
   rxfc_char_t sk_c;
   logic       sk_v;
   logic       sk_rdy;
   logic [3:0] m;
   wire  [7:0] mask = WLEN_MASK[lcr_q[1:0]];
   wire  [3:0][7:0] ref_chr = {special_char_q, xoff1_q, xon2_q, xon1_q};

   rxfc_skid u_skid (
      .clk       (CLK_SYS),
      .rst       (RST),
      .in_valid  (RX_VALID),
      .in_ready  (RX_READY),
      .in_data   (RX_CHAR),
      .out_valid (sk_v),
      .out_ready (sk_rdy),
      .out_data  (sk_c)
   );

   for (genvar i = 0; i < 4; i++) begin : g_cmp
      rxfc_match u_match (
         .a    (sk_c.data),
         .b    (ref_chr[i]),
         .mask (mask),
         .hit  (m[i])
      );
   end

   // m: 0 resume1, 1 resume2, 2 pause1, 3 pause2; efr[1:0] picks the mode
   wire [1:0] swm     = efr_q[1:0];
   wire       s_off   = (swm == 2'h1 & m[2]) | (swm == 2'h2 & m[3]); // RULE24
   wire       s_on    = (swm == 2'h1 & m[0]) | (swm == 2'h2 & m[1]); // RULE24
   wire       f_off   = (swm == 2'h3) & m[2]; // RULE17
   wire       f_on    = (swm == 2'h3) & m[0]; // RULE17
   wire       second  = held_on_q ? m[1] : m[3];
   wire       w_pair  = sk_v & held_v_q & second; // RULE17
   wire       w_flush = sk_v & held_v_q & ~second;
   wire       w_sngl  = sk_v & ~held_v_q & (s_off | s_on);
   wire       w_first = sk_v & ~held_v_q & ~(s_off | s_on) & (f_off | f_on);
   wire       w_plain = sk_v & ~held_v_q & ~(s_off | s_on) & ~(f_off | f_on);
   // matched flow characters are taken from the buffer but never pushed
   wire       push    = (w_flush | w_plain) & ~full; // RULE18 RULE8
   wire       det_off = (w_pair & ~held_on_q) | (w_sngl & s_off); // RULE14
   wire       det_on  = (w_pair & held_on_q) | (w_sngl & s_on & ~s_off); // RULE15
   wire       special = w_plain & efr_q[5] & m[3] & ~full; // RULE21
   rxfc_char_t push_c;
   assign push_c = w_flush ? held_q : sk_c;
   // a flush leaves the new character waiting; it is judged next cycle
   assign sk_rdy = w_pair | w_sngl | w_first | (w_plain & ~full);

   // ----------------------------------------------------------------
   // receive fifo
   // ----------------------------------------------------------------
   wire rxfc_char_t head = mem_q[rp_q];

   always_ff @(posedge CLK_SYS) begin
      if (push) begin
         mem_q[wp_q] <= push_c; // RULE1
      end
   end

   // pointers and fill count; a read steps to the next entry and tags
   always_ff @(posedge CLK_SYS) begin
      if (RST | fifo_clr) begin
         wp_q  <= 5'h00;
         rp_q  <= 5'h00;
         cnt_q <= 6'h00;
      end else begin
         wp_q  <= wp_q + {4'h0, push};
         rp_q  <= rp_q + {4'h0, rhr_rd}; // RULE2
         cnt_q <= cnt_q + {5'h00, push} - {5'h00, rhr_rd};
      end
   end

   // first half of a double match waits here for its partner
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         held_v_q  <= 1'b0;
         held_on_q <= 1'b0;
         held_q    <= '0;
      end else if (w_first) begin
         held_v_q  <= 1'b1;
         held_on_q <= f_on & ~f_off;
         held_q    <= sk_c;
      end else if (w_pair | (w_flush & ~full)) begin
         held_v_q  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ier_q      <= RST_REG;
         lcr_q      <= RST_LCR;
         mcr_q      <= RST_REG;
         efr_q      <= RST_REG;
         xon1_q     <= RST_REG; // RULE16
         xon2_q     <= RST_REG; // RULE16
         xoff1_q    <= RST_REG; // RULE16
         special_char_q    <= RST_REG; // RULE16
         fifo_en_q  <= 1'b0;
         trig_sel_q <= 2'h0;
      end else begin
         if (wr_ier) ier_q <= ier_d;
         if (wr_lcr) lcr_q <= WDATA;
         if (wr_mcr) mcr_q <= mcr_d;
         if (wr_efr) efr_q <= WDATA;
         if (wr_x1n) xon1_q <= WDATA;
         if (wr_x2n) xon2_q <= WDATA;
         if (wr_x1f) xoff1_q <= WDATA;
         if (wr_x2f) special_char_q <= WDATA;
         if (wr_fcr) begin
            fifo_en_q  <= WDATA[0];
            trig_sel_q <= WDATA[7:6];
         end
      end
   end

   // ----------------------------------------------------------------
   // request line with hysteresis
   // ----------------------------------------------------------------
   // held high until mcr bit 1 asserts it, so auto control starts there
   wire rts_n_d = ~mcr_q[1]   ? 1'b1 :    // RULE4
                  ~efr_q[6]   ? 1'b0 :    // RULE3
                  cnt_q >= hi ? 1'b1 :    // RULE6
                  cnt_q <= lo ? 1'b0 :    // RULE7
                  rts_n_q;
   wire rts_rise = rts_n_d & ~rts_n_q;
   wire cts_rise = CTS_N & ~cts_q;
   wire rx_int   = fifo_en_q ? (cnt_q >= trig) : (cnt_q != 6'h00); // RULE9
   // pause state only lives while a matching mode is selected
   wire pause_d  = (swm != 2'h0) & (det_off | (paused_q & ~det_on));
   wire hold_d   = pause_d | (efr_q[7] & CTS_N); // RULE10 RULE12 RULE14

   // ----------------------------------------------------------------
   // status flags, hold and interrupt
   // ----------------------------------------------------------------
   // set beats a clearing status read in the same cycle
   wire set4 = (det_off & ier_q[5]) | special; // RULE15 RULE21
   wire set5 = (rts_rise & ier_q[6]) | (cts_rise & ier_q[7]); // RULE5 RULE11

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         flag4_q  <= 1'b0;
         flag5_q  <= 1'b0;
         paused_q <= 1'b0;
         cts_q    <= 1'b0;
         rts_n_q  <= 1'b1;
         hold_q   <= 1'b0;
         int_q    <= 1'b0;
      end else begin
         flag4_q  <= set4 | (flag4_q & ~rd_isr & ~det_on); // RULE15
         flag5_q  <= set5 | (flag5_q & ~rd_isr);
         paused_q <= pause_d;
         cts_q    <= CTS_N;
         rts_n_q  <= rts_n_d;
         hold_q   <= hold_d;
         int_q    <= (rx_int & ier_q[0]) | set4 | set5
                     | ((flag4_q | flag5_q) & ~rd_isr);
      end
   end

   // the transmitter samples the hold only between characters
   assign TX_HOLD = hold_q;
   assign RTS_N   = rts_n_q;
   assign INT     = int_q;

   // ----------------------------------------------------------------
   // automatic pause and resume sending
   // ----------------------------------------------------------------
   wire [1:0] txm  = efr_q[3:2];
   wire       sent = SEND_VALID & SEND_READY;

   always_comb begin
      fc_d = fc_q;
      unique case (fc_q)
         FC_IDLE:   if (cnt_q >= trig) fc_d = FC_WAIT;
         FC_WAIT: begin
            if (cnt_q <= lo) fc_d = FC_IDLE;
            else if (ticks_q == PAUSE_WAIT) fc_d = FC_OFF1; // RULE19
         end
         FC_OFF1:   if (sent) fc_d = (txm == 2'h3) ? FC_OFF2 : FC_PAUSED;
         FC_OFF2:   if (sent) fc_d = FC_PAUSED;
         FC_PAUSED: if (cnt_q <= lo) fc_d = FC_ON1; // RULE20
         FC_ON1:    if (sent) fc_d = (txm == 2'h3) ? FC_ON2 : FC_IDLE;
         FC_ON2:    if (sent) fc_d = FC_IDLE;
         default:   fc_d = FC_IDLE;
      endcase
      if (txm == 2'h0) fc_d = FC_IDLE; // RULE24
   end

   // mode 2 sends only the second character of each pair
   wire [7:0] chr_d = (fc_d == FC_OFF1) ? ((txm == 2'h2) ? special_char_q : xoff1_q) :
                      (fc_d == FC_OFF2) ? special_char_q :
                      (fc_d == FC_ON1)  ? ((txm == 2'h2) ? xon2_q : xon1_q) :
                      xon2_q;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         fc_q    <= FC_IDLE;
         ticks_q <= 2'h0;
         send_q  <= RST_REG;
      end else begin
         fc_q    <= fc_d;
         ticks_q <= (fc_q != FC_WAIT) ? 2'h0 : ticks_q + {1'b0, CHAR_TICK};
         send_q  <= chr_d;
      end
   end

   assign SEND_VALID = (fc_q == FC_OFF1) | (fc_q == FC_OFF2)
                     | (fc_q == FC_ON1) | (fc_q == FC_ON2);
   assign SEND_DATA  = send_q;

   // ----------------------------------------------------------------
   // register reads, answered one cycle after the strobe
   // ----------------------------------------------------------------
   wire [7:0] interrupt_status_reg = {fifo_en_q, fifo_en_q, flag5_q, flag4_q, 1'b0, rx_int, 1'b0, ~int_q};
   wire [7:0] line_status_reg = {3'h0, head.err, 1'b0, cnt_q != 6'h00}; // RULE2
   wire [7:0] rd_enh = (ADDR == OFS_EFR)   ? efr_q :
                       (ADDR == OFS_LCR)   ? lcr_q :
                       (ADDR == OFS_XON1)  ? xon1_q :
                       (ADDR == OFS_XON2)  ? xon2_q :
                       (ADDR == OFS_XOFF1) ? xoff1_q :
                       (ADDR == OFS_SPECIAL_CHAR) ? special_char_q : 8'h00;
   wire [7:0] rd_norm = (ADDR == OFS_RHR) ? head.data :
                        (ADDR == OFS_IER) ? ier_q :
                        (ADDR == OFS_ISR) ? interrupt_status_reg :
                        (ADDR == OFS_LCR) ? lcr_q :
                        (ADDR == OFS_MCR) ? mcr_q :
                        (ADDR == OFS_LSR) ? line_status_reg : 8'h00;
   wire [7:0] rd_val = enh ? rd_enh : norm ? rd_norm :
                       (ADDR == OFS_LCR) ? lcr_q : 8'h00;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rdata_q <= RST_REG;
      end else if (RD_STB) begin
         rdata_q <= rd_val;
      end
   end
   assign RDATA = rdata_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   a_fifo_depth_cap: assert property (cnt_q <= FIFO_FULL) // RULE1
      else $error("fifo count above depth");
   a_rhr_read_pop: assert property ((rhr_rd & ~push & ~fifo_clr) |=> cnt_q == $past(cnt_q) - 6'h01) // RULE2
      else $error("read did not advance fifo");
   a_rts_goes_high: assert property ((mcr_q[1] & efr_q[6] & cnt_q >= hi) |=> RTS_N) // RULE6
      else $error("request line not deasserted");
   a_rts_goes_low: assert property ((mcr_q[1] & efr_q[6] & cnt_q <= lo & cnt_q < hi) |=> !RTS_N) // RULE7
      else $error("request line not reasserted");
   a_rts_needs_mcr: assert property (!mcr_q[1] |=> RTS_N) // RULE4
      else $error("request line low without modem control");
   a_accept_not_full: assert property ((w_plain & ~full) |-> push ##1 cnt_q != 6'h00) // RULE8
      else $error("character refused below full");
   a_rx_trig_int: assert property ((fifo_en_q & ier_q[0] & cnt_q >= trig) |=> INT) // RULE9
      else $error("trigger interrupt missing");
   a_cts_hold_tx: assert property ((efr_q[7] & CTS_N) |=> TX_HOLD) // RULE12
      else $error("transmit not held on clear-to-send");
   a_flow_chr_drop: assert property ((w_pair | w_sngl) |-> !push) // RULE18
      else $error("flow character entered fifo");
   a_rts_irq_flag: assert property ((rts_rise & ier_q[6]) |=> flag5_q && INT) // RULE5
      else $error("request rise not flagged");
   a_pause_wait: assert property ((fc_q == FC_WAIT && fc_d == FC_OFF1) |-> ticks_q == 2'h2) // RULE19
      else $error("pause sent without two character times");
endmodule
`default_nettype wire

// File: common/rxfc_pkg.sv
// package of constants and types for the uart receive path and flow control block
// Summary of operation
// RULE1: received characters sit in a 32-deep fifo, eight data bits plus three error tags.
// RULE2: holding register shows oldest character; a read advances it and refreshes line status tags.
// RULE3: enhanced feature bit 6 enables automatic hardware receive flow control.
// RULE4: auto request control starts only after modem control bit 1 asserts the request line.
// RULE5: request line rising sets status bit 5 and interrupts when interrupt-enable bit 6 set.
// RULE6: request line goes high at fill 16, 24, 30, 30 for levels 8, 16, 24, 30.
// RULE7: request line returns low at fill 0, 8, 16, 24 for levels 8, 16, 24, 30.
// RULE8: while request is high, characters are still accepted until the fifo is full.
// RULE9: receive data interrupt fires when fill reaches the selected trigger level.
// RULE10: enhanced feature bit 7 enables clear-to-send transmit gating.
// RULE11: clear-to-send rising sets status bit 5 and interrupts when interrupt-enable bit 7 set.
// RULE12: with clear-to-send high the transmitter stops after the current stop bit.
// RULE13: the remote transmitter stops after its current character while our request is high.
// RULE14: received pause characters halt transmission after the character being sent.
// RULE15: pause match sets the pause flag and interrupt; resume match restarts and clears it.
// RULE16: reset clears the four flow characters to zero; afterwards any value is writable.
// RULE17: double mode needs two consecutive characters matching first and second values.
// RULE18: matched flow control characters never enter the receive fifo.
// RULE19: pause characters go out two character times after the fill crosses the trigger.
// RULE20: resume characters go out when fill drops to 0, 8, 16 or 24.
// RULE21: with enhanced bit 5, the special character is stored and sets status bit 4.
// RULE22: comparisons use only the word length bits from line control bits 0-1.
// RULE23: enhanced interrupt-enable and modem-control bits write only with enhanced bit 4.
// RULE24: software selects none, single or double matching and automatic pause/resume sending.
package rxfc_pkg;
   // register offsets on the three address lines
   localparam logic [2:0] OFS_RHR   = 3'h0;
   localparam logic [2:0] OFS_IER   = 3'h1;
   localparam logic [2:0] OFS_ISR   = 3'h2;
   localparam logic [2:0] OFS_LCR   = 3'h3;
   localparam logic [2:0] OFS_MCR   = 3'h4;
   localparam logic [2:0] OFS_LSR   = 3'h5;
   localparam logic [2:0] OFS_EFR   = 3'h2;
   localparam logic [2:0] OFS_XON1  = 3'h4;
   localparam logic [2:0] OFS_XON2  = 3'h5;
   localparam logic [2:0] OFS_XOFF1 = 3'h6;
   localparam logic [2:0] OFS_SPECIAL_CHAR = 3'h7;
   localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
   // reset values
   localparam logic [7:0] RST_REG  = 8'h00;
   localparam logic [7:0] RST_LCR  = 8'h03;
   // fifo geometry
   localparam int         FIFO_DEPTH = 32;
   localparam logic [5:0] FIFO_FULL  = 6'h20;
   // per trigger select 0..3: trigger, deassert and reassert fill counts
   localparam logic [3:0][5:0] TRIG_LVL = {6'h1E, 6'h18, 6'h10, 6'h08};
   localparam logic [3:0][5:0] HI_LVL   = {6'h1E, 6'h1E, 6'h18, 6'h10};
   localparam logic [3:0][5:0] LO_LVL   = {6'h18, 6'h10, 6'h08, 6'h00};
   // character times waited before pause characters go out
   localparam logic [1:0] PAUSE_WAIT = 2'h2;
   // word length masks for line control bits 1:0
   localparam logic [3:0][7:0] WLEN_MASK = {8'hFF, 8'h7F, 8'h3F, 8'h1F};

   typedef struct packed {
      logic [2:0] err;
      logic [7:0] data;
   } rxfc_char_t;

   typedef enum logic [2:0] {
      FC_IDLE, FC_WAIT, FC_OFF1, FC_OFF2, FC_PAUSED, FC_ON1, FC_ON2
   } rxfc_fc_t;
endpackage

// File: logic/rxfc_match.sv
// masked character comparator for flow control and special character detection
`timescale 1ns/100ps
`default_nettype none
module rxfc_match import rxfc_pkg::*; (
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic [7:0] mask,
   output logic            hit
);
   // bits above the word length never take part
   assign hit = ((a ^ b) & mask) == 8'h00; // RULE22
endmodule
`default_nettype wire

// File: logic/rxfc_skid.sv
// two-entry buffer between the receive shift register and the fifo logic
`timescale 1ns/100ps
`default_nettype none
module rxfc_skid import rxfc_pkg::*; (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire rxfc_char_t in_data,
   output logic            out_valid,
   input  wire logic       out_ready,
   output rxfc_char_t      out_data
);
   rxfc_char_t      buf_q [2];
   logic            wp_q;
   logic            rp_q;
   logic      [1:0] cnt_q;
   wire             put = in_valid & in_ready;
   wire             take = out_valid & out_ready;

   // ready drops when both slots are held, so a stall loses nothing
   assign in_ready  = cnt_q != 2'h2;
   assign out_valid = cnt_q != 2'h0;
   assign out_data  = buf_q[rp_q];

   // ----------------------------------------------------------------
   // storage and pointers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (put) begin
         buf_q[wp_q] <= in_data;
      end
      if (rst) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         wp_q  <= wp_q ^ put;
         rp_q  <= rp_q ^ take;
         cnt_q <= cnt_q + {1'b0, put} - {1'b0, take};
      end
   end

   a_skid_no_overfill: assert property (@(posedge clk) disable iff (rst)
      cnt_q <= 2'h2) else $error("skid buffer holds more than two");
endmodule
`default_nettype wire

// File: verification/rxfc_remote.sv
// model of the remote uart: feeds received characters, takes flow characters
`timescale 1ns/100ps
`default_nettype none
module rxfc_remote import rxfc_pkg::*; (
   input  wire logic       clk,
   input  wire logic       rts_n,
   input  wire logic       rx_ready,
   output logic            rx_valid,
   output rxfc_char_t      rx_char,
   input  wire logic       send_valid,
   input  wire logic [7:0] send_data,
   output logic            send_ready
);
   rxfc_char_t q[$];
   logic [7:0] got[$];
   logic       obey = 1'b1;
   logic       slow = 1'b0;
   logic       tk;
   initial begin
      rx_valid = 1'b0;
      rx_char = '0;
      send_ready = 1'b1;
   end
   // an offer stands until taken; idle data wanders so stale values never match
   always @(posedge clk) begin
      tk = rx_valid && rx_ready;
      if (send_valid && send_ready)
         got.push_back(send_data);
      #1;
      if (tk)
         void'(q.pop_front());
      if (tk || !rx_valid) begin
         rx_valid = q.size() > 0 && (!obey || !rts_n);
         rx_char = rx_valid ? q[0] : ~rx_char;
      end
      send_ready = !slow || !send_ready;
   end
endmodule
`default_nettype wire

// File: verification/tb.sv
// self-checking bench of the receive fifo and flow control block
`timescale 1ns/100ps
`default_nettype none
module tb import rxfc_pkg::*;;
   logic       clk = 0;
   logic       rst = 1;
   logic       wr = 0;
   logic       rd = 0;
   logic       tick = 0;
   logic       cts_n = 0;
   logic [2:0] adr = '0;
   logic [7:0] wd = '0;
   logic [7:0] rdat, sd;
   logic       rxv, rxr, hold, sv, sr, rts_n, irq;
   rxfc_char_t rc;
   int         bad_count = 0;
   int         check_count = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   rxfc_top dut (.CLK_SYS(clk), .RST(rst), .ADDR(adr), .WR_STB(wr), .RD_STB(rd), .WDATA(wd),
      .RDATA(rdat), .RX_CHAR(rc), .RX_VALID(rxv), .RX_READY(rxr), .CHAR_TICK(tick), .CTS_N(cts_n),
      .TX_HOLD(hold), .SEND_VALID(sv), .SEND_DATA(sd), .SEND_READY(sr), .RTS_N(rts_n), .INT(irq));
   rxfc_remote rem (.clk(clk), .rts_n(rts_n), .rx_ready(rxr), .rx_valid(rxv), .rx_char(rc),
      .send_valid(sv), .send_data(sd), .send_ready(sr));
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic b_chk(input string n, input logic s, input logic e);
      chk(n, {7'h0, s}, {7'h0, e});
   endtask
   // strobes rise just after an edge and last one cycle
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      adr = a;
      wd = d;
      wr = 1;
      @(posedge clk) #1;
      wr = 0;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk) #1;
      adr = a;
      rd = 1;
      @(posedge clk) #1;
      rd = 0;
      d = rdat;
   endtask
   task automatic ck_reg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
      logic [7:0] d;
      rd_reg(a, d);
      chk(n, d & m, e);
   endtask
   task automatic send(input logic [7:0] v, input logic [2:0] e);
      rem.q.push_back({e, v});
   endtask
   // bounded wait until the remote end has handed over every character
   task automatic drain;
      for (int k = 0; rem.q.size() > 0; k++) begin
         if (k > 300) begin
            bad_count++;
            final_report();
         end
         @(posedge clk);
      end
      // settle off the edge so later stimulus and checks never race it
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic pair(input logic [7:0] a, input logic [7:0] b);
      send(a, 3'h0);
      send(b, 3'h0);
      drain();
   endtask
   task automatic pulse;
      @(posedge clk) #1;
      tick = 1;
      @(posedge clk) #1;
      tick = 0;
   endtask
   task automatic t_regs;
      ck_reg(OFS_LCR, 8'hFF, RST_LCR, "lcr");
      b_chk("rts reset", rts_n, 1'b1);
      wr_reg(OFS_IER, 8'hF0);
      ck_reg(OFS_IER, 8'hFF, 8'h00, "ier lock");
      wr_reg(OFS_LCR, LCR_ENH_KEY);
      for (int i = 4; i < 8; i++) ck_reg(3'(i), 8'hFF, RST_REG, "flow rst");
      for (int i = 4; i < 8; i++) wr_reg(3'(i), 8'hF0 + 8'(i));
      for (int i = 4; i < 8; i++) ck_reg(3'(i), 8'hFF, 8'hF0 + 8'(i), "flow wr");
      ck_reg(3'h0, 8'hFF, 8'h00, "unmapped");
   endtask
   // trigger 16: interrupt at 16, request off at 24, back on at 8
   task automatic t_hw;
      wr_reg(OFS_EFR, 8'h50);
      wr_reg(OFS_LCR, RST_LCR);
      wr_reg(OFS_ISR, 8'h41);
      wr_reg(OFS_IER, 8'h41);
      wr_reg(OFS_MCR, 8'h02);
      // the request line is registered one cycle behind the modem control bit
      @(posedge clk) #1;
      b_chk("rts on", rts_n, 1'b0);
      for (int i = 0; i < 32; i++) begin
         send(8'(i), 3'(i));
         drain();
         if (i == 14) ck_reg(OFS_ISR, 8'h04, 8'h00, "trig 15");
         if (i == 15) ck_reg(OFS_ISR, 8'h04, 8'h04, "trig 16");
         if (i == 22) b_chk("rts 23", rts_n, 1'b0);
         if (i == 23) b_chk("rts 24", rts_n, 1'b1);
         if (i == 23) ck_reg(OFS_ISR, 8'h20, 8'h20, "rts flag");
         rem.obey = i < 23;
      end
      for (int i = 0; i < 32; i++) begin
         ck_reg(OFS_LSR, 8'h1C, {3'h0, 3'(i), 2'h0}, "tags");
         ck_reg(OFS_RHR, 8'hFF, 8'(i), "rhr");
         @(posedge clk) #1;
         if (i == 22 || i == 23) b_chk("rts drain", rts_n, i == 22);
      end
   endtask
   task automatic t_sw;
      wr_reg(OFS_LCR, LCR_ENH_KEY);
      wr_reg(OFS_XON1, 8'h11);
      wr_reg(OFS_XON2, 8'h91);
      wr_reg(OFS_XOFF1, 8'h13);
      wr_reg(OFS_SPECIAL_CHAR, 8'h93);
      wr_reg(OFS_EFR, 8'h93);
      wr_reg(OFS_LCR, RST_LCR);
      wr_reg(OFS_ISR, 8'h01);
      wr_reg(OFS_IER, 8'hA0);
      pair(8'h13, 8'h93);
      b_chk("paused", hold, 1'b1);
      b_chk("pause int", irq, 1'b1);
      ck_reg(OFS_LSR, 8'h01, 8'h00, "dropped");
      pair(8'h11, 8'h91);
      b_chk("resumed", hold, 1'b0);
      b_chk("int off", irq, 1'b0);
      pair(8'h13, 8'h55);
      b_chk("no pair", hold, 1'b0);
      ck_reg(OFS_RHR, 8'hFF, 8'h13, "held");
      ck_reg(OFS_RHR, 8'hFF, 8'h55, "next");
      wr_reg(OFS_LCR, 8'h02);
      pair(8'h93, 8'h13);
      b_chk("7b pause", hold, 1'b1);
      pair(8'h91, 8'h11);
      b_chk("7b resume", hold, 1'b0);
      cts_n = 1;
      repeat (4) @(posedge clk);
      b_chk("cts stop", hold, 1'b1);
      ck_reg(OFS_ISR, 8'h20, 8'h20, "cts flag");
      cts_n = 0;
      repeat (4) @(posedge clk);
      b_chk("cts go", hold, 1'b0);
   endtask
   // trigger 8 with a slow remote end; last char equals the special value
   task automatic t_auto;
      logic [7:0] d;
      wr_reg(OFS_LCR, LCR_ENH_KEY);
      wr_reg(OFS_EFR, 8'h34);
      wr_reg(OFS_LCR, RST_LCR);
      rem.slow = 1;
      for (int i = 0; i < 7; i++) send(8'h20 + 8'(i), 3'h0);
      pair(8'h93, 8'h93);
      ck_reg(OFS_ISR, 8'h10, 8'h10, "special");
      pulse();
      b_chk("one tick", sv, 1'b0);
      pulse();
      repeat (8) @(posedge clk);
      chk("pause tx", rem.got[$], 8'h13);
      for (int i = 0; i < 9; i++) rd_reg(OFS_RHR, d);
      chk("kept", d, 8'h93);
      repeat (8) @(posedge clk);
      chk("resume tx", rem.got[$], 8'h11);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 rst = 0;
      t_regs();
      t_hw();
      t_sw();
      t_auto();
      final_report();
   end
endmodule
`default_nettype wire
